// ---- esr_pkg.sv ----
// shared constants and types for the serial eeprom read sequencer
package esr_pkg;
  localparam int          ESR_ADDR_W    = 9;        // memory address width
  localparam int          ESR_MEM_DEPTH = 512;      // bytes held
  localparam logic [3:0]  ESR_BYTE_BITS = 4'h8;     // bits per byte on the wire
  localparam logic [3:0]  ESR_LAST_BIT  = 4'h7;     // index of the last received bit
  localparam logic [8:0]  ESR_ADDR_RST  = 9'h000;   // address counter after reset
  localparam logic [8:0]  ESR_ADDR_ONE  = 9'h001;   // counter step

  // serial protocol phases
  typedef enum logic [2:0] {
    ESR_IDLE, ESR_DEVADDR, ESR_DEV_ACK, ESR_MEMADDR, ESR_MEM_ACK, ESR_RD_DATA, ESR_RD_ACK, ESR_IGNORE
  } esr_state_t;
endpackage : esr_pkg

// ---- esr_line_if.sv ----
// bus line events carried from the line monitor to the sequencer
`timescale 1ns/1ps
interface esr_line_if;
  logic scl_rise;  // clock line rose
  logic scl_fall;  // clock line fell
  logic start;     // start or repeated start seen
  logic stop;      // stop seen
  logic sda_lvl;   // synchronised data line level

  modport mon (output scl_rise, scl_fall, start, stop, sda_lvl);
  modport seq (input  scl_rise, scl_fall, start, stop, sda_lvl);
endinterface : esr_line_if

// ---- esr_line_mon.sv ----
// synchronises the two bus lines and finds their edges and framing conditions
`timescale 1ns/1ps
module esr_line_mon
  import esr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  esr_line_if.mon   ev
);
  logic [1:0] scl_sync_reg;  // two-stage synchroniser, clock line
  logic [1:0] sda_sync_reg;  // two-stage synchroniser, data line
  logic       scl_prev_reg;  // last synchronised clock level
  logic       sda_prev_reg;  // last synchronised data level

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
    end
  end

  // one more stage for edge detection, reads only the second flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: data moving while the clock stays high frames a transfer
  assign ev.scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  assign ev.scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  assign ev.start    = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign ev.stop     = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  assign ev.sda_lvl  = sda_sync_reg[1];
endmodule : esr_line_mon

// ---- esr_top.sv ----
// read sequencer of a 512 byte two-wire serial eeprom slave
// How it works
// - counter holds last accessed location plus one
// - acknowledge match, then send byte at counter
// - counter increments after every byte sent
// - sequential read follows either read kind
// - on master ack, send next location
// - counter wraps from top to zero
// - nack then stop ends read, release
// - nine bit address, top bit in slave byte
// - last slave byte bit selects direction
// - respond only when chip selects match pins
// - data bit changes on clock falling edge
`timescale 1ns/1ps
module esr_top
  import esr_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h6  // device type code, arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       chip_select_low_pin_i,
  input  wire logic       chip_select_high_pin_i,
  input  wire logic       mem_wr_en_i,
  input  wire logic [8:0] mem_wr_addr_i,
  input  wire logic [7:0] mem_wr_data_i
);
  esr_line_if ev ();  // edge and framing events

  esr_line_mon u_mon (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev.mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [7:0]  mem [ESR_MEM_DEPTH];  // array contents, filled by the write port
  esr_state_t  state_reg;            // protocol phase
  logic [3:0]  bit_cnt_reg;          // bits moved in the current byte
  logic [7:0]  shift_reg;            // received byte
  logic [7:0]  tx_reg;               // byte being sent, msb first
  logic        rw_reg;               // direction bit of the last slave byte
  logic        top_reg;              // address top bit from the slave byte
  logic        ack_on_reg;           // we are inside our own acknowledge slot
  logic        got_ack_reg;          // master acknowledged the last data byte
  logic        drive_low_reg;        // pull the data line low
  logic [8:0]  addr_cnt_reg;         // memory address counter
  logic [7:0]  rd_byte;              // byte at the counter
  logic [7:0]  rx_byte;              // received byte including the bit on the line
  logic        cs_match;             // slave byte selects this device
  logic        cnt_inc;              // one byte has been shifted out
  logic        cnt_load;             // memory address byte acknowledged
  logic [1:0]  cs_lo_sync_reg;       // two-stage synchroniser, low chip select pin
  logic [1:0]  cs_hi_sync_reg;       // two-stage synchroniser, high chip select pin

  assign rd_byte  = mem[addr_cnt_reg];
  assign rx_byte  = {shift_reg[6:0], ev.sda_lvl};
  assign cs_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3] == cs_hi_sync_reg[1])
                    && (rx_byte[2] == cs_lo_sync_reg[1]);
  assign cnt_inc  = (state_reg == ESR_RD_DATA) && ev.scl_fall && (bit_cnt_reg == ESR_BYTE_BITS);
  assign cnt_load = (state_reg == ESR_MEM_ACK) && ev.scl_fall && ack_on_reg;

  // open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_low_reg;

  ////////////////////////////////////////////////////////////////////////////
  // chip select straps are pins too; a strap moved live must not glitch the match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_lo_sync_reg <= 2'h0;
      cs_hi_sync_reg <= 2'h0;
    end else begin
      cs_lo_sync_reg <= {cs_lo_sync_reg[0], chip_select_low_pin_i};
      cs_hi_sync_reg <= {cs_hi_sync_reg[0], chip_select_high_pin_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory fill port, also where the write side reports its accesses
  always_ff @(posedge clk_i) begin
    if (mem_wr_en_i) begin
      mem[mem_wr_addr_i] <= mem_wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address counter: plain 9-bit add so the top location rolls to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_cnt_reg <= ESR_ADDR_RST;
    end else if (cnt_load) begin
      addr_cnt_reg <= {top_reg, shift_reg};
    end else if (cnt_inc) begin
      addr_cnt_reg <= addr_cnt_reg + ESR_ADDR_ONE;
    end else if (mem_wr_en_i) begin
      addr_cnt_reg <= mem_wr_addr_i + ESR_ADDR_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol sequencer; stop beats start beats clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ESR_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      rw_reg        <= 1'b0;
      top_reg       <= 1'b0;
      ack_on_reg    <= 1'b0;
      got_ack_reg   <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (ev.stop) begin
      state_reg     <= ESR_IDLE;
      drive_low_reg <= 1'b0;
    end else if (ev.start) begin
      // a repeated start also lands here, so a dummy write chains into a read
      state_reg     <= ESR_DEVADDR;
      bit_cnt_reg   <= 4'h0;
      ack_on_reg    <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        // receive slave byte on rising edges
        ESR_DEVADDR: begin
          if (ev.scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == ESR_LAST_BIT) begin
              rw_reg    <= rx_byte[0];
              state_reg <= cs_match ? ESR_DEV_ACK : ESR_IGNORE;
              if (!rx_byte[0]) begin
                top_reg <= rx_byte[1];
              end
            end
          end
        end
        // acknowledge slot: pull low on one fall, leave it on the next
        ESR_DEV_ACK: begin
          if (ev.scl_fall) begin
            if (!ack_on_reg) begin
              ack_on_reg    <= 1'b1;
              drive_low_reg <= 1'b1;
            end else if (rw_reg) begin
              ack_on_reg    <= 1'b0;
              state_reg     <= ESR_RD_DATA;
              bit_cnt_reg   <= 4'h1;
              tx_reg        <= {rd_byte[6:0], 1'b0};
              drive_low_reg <= ~rd_byte[7];
            end else begin
              ack_on_reg    <= 1'b0;
              drive_low_reg <= 1'b0;
              state_reg     <= ESR_MEMADDR;
              bit_cnt_reg   <= 4'h0;
            end
          end
        end
        // low address byte of a dummy write
        ESR_MEMADDR: begin
          if (ev.scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == ESR_LAST_BIT) begin
              state_reg <= ESR_MEM_ACK;
            end
          end
        end
        // data bytes of a real write belong to the write side, so sit out
        ESR_MEM_ACK: begin
          if (ev.scl_fall) begin
            if (!ack_on_reg) begin
              ack_on_reg    <= 1'b1;
              drive_low_reg <= 1'b1;
            end else begin
              ack_on_reg    <= 1'b0;
              drive_low_reg <= 1'b0;
              state_reg     <= ESR_IGNORE;
            end
          end
        end
        // shift a byte out, one bit per falling edge
        ESR_RD_DATA: begin
          if (ev.scl_fall) begin
            if (bit_cnt_reg == ESR_BYTE_BITS) begin
              drive_low_reg <= 1'b0;
              got_ack_reg   <= 1'b0;
              state_reg     <= ESR_RD_ACK;
            end else begin
              drive_low_reg <= ~tx_reg[7];
              tx_reg        <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg   <= bit_cnt_reg + 4'h1;
            end
          end
        end
        // master acknowledge slot: low asks for more, high ends the read
        ESR_RD_ACK: begin
          if (ev.scl_rise) begin
            if (ev.sda_lvl) begin
              state_reg <= ESR_IGNORE;
            end else begin
              got_ack_reg <= 1'b1;
            end
          end else if (ev.scl_fall && got_ack_reg) begin
            state_reg     <= ESR_RD_DATA;
            bit_cnt_reg   <= 4'h1;
            tx_reg        <= {rd_byte[6:0], 1'b0};
            drive_low_reg <= ~rd_byte[7];
          end
        end
        // released until the next start or stop
        ESR_IGNORE: begin
          drive_low_reg <= 1'b0;
        end
        default: begin
          state_reg     <= ESR_IDLE;
          drive_low_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_nomatch_released: assert property (
    (state_reg == ESR_IGNORE) ##1 (state_reg == ESR_IGNORE) |-> !sda_oe_o)
    else $error("line driven while ignoring");
  a_cs_mismatch: assert property (
    (state_reg == ESR_DEVADDR) && ev.scl_rise && !ev.stop && !ev.start
    && (bit_cnt_reg == ESR_LAST_BIT) && !cs_match |=> (state_reg == ESR_IGNORE))
    else $error("mismatched slave byte not ignored");
  a_ack_low: assert property ((state_reg == ESR_DEV_ACK) && ack_on_reg |-> sda_oe_o)
    else $error("slave byte not acknowledged");
  a_first_bit: assert property (
    (state_reg == ESR_DEV_ACK) && ack_on_reg && rw_reg && ev.scl_fall && !ev.stop && !ev.start
    |=> (sda_oe_o == !$past(rd_byte[7])) && (state_reg == ESR_RD_DATA))
    else $error("first data bit wrong");
  a_addr_inc_wrap: assert property (
    cnt_inc |=> (addr_cnt_reg == 9'($past(addr_cnt_reg) + 9'h001)))
    else $error("counter did not step or wrap");
  a_memaddr_load: assert property (
    cnt_load |=> (addr_cnt_reg == {$past(top_reg), $past(shift_reg)}))
    else $error("dummy write did not load counter");
  a_master_ack_slot: assert property ((state_reg == ESR_RD_ACK) |-> !sda_oe_o)
    else $error("line driven in master ack slot");
  a_nack_ends: assert property (
    (state_reg == ESR_RD_ACK) && ev.scl_rise && ev.sda_lvl && !ev.stop
    |=> (state_reg == ESR_IGNORE) ##1 !sda_oe_o)
    else $error("nack did not end read");
  a_stop_release: assert property (ev.stop |=> (state_reg == ESR_IDLE) && !sda_oe_o)
    else $error("stop did not release line");
  a_change_on_fall: assert property (
    $rose(sda_oe_o) && (state_reg == ESR_RD_DATA) |-> $past(ev.scl_fall))
    else $error("data changed off falling edge");

  c_single_read: cover property ((state_reg == ESR_RD_ACK) && ev.scl_rise && ev.sda_lvl);
  c_sequential: cover property ((state_reg == ESR_RD_ACK) && ev.scl_fall && got_ack_reg);
  c_wrap: cover property (cnt_inc && (addr_cnt_reg == 9'h1FF));
  c_dummy_write: cover property (cnt_load);
endmodule : esr_top

// ---- esr_master_model.sv ----
// two-wire bus master model driving the clock line and pulling the data line
`timescale 1ns/1ps
module esr_master_model (
  input  wire logic clk_i,      // system clock, changes land on its falling edge
  input  wire logic sda_line_i, // resolved data line
  output logic      scl_o,      // bus clock, stands high outside frames
  output logic      sda_low_o   // high while the master pulls data low
);
  int lo_wait = 4; // clock low time in system cycles, raised to act slowly

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait falling system clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // one bus clock; data moves mid-low, the line is read late in the high phase
  task automatic bit_io(input logic b, output logic s);
    tick(lo_wait / 2);
    sda_low_o = ~b;
    tick(lo_wait - lo_wait / 2);
    scl_o = 1'b1;
    tick(3);
    s = sda_line_i;
    tick(1);
    scl_o = 1'b0;
  endtask : bit_io

  // start from idle, or repeated start when the clock is low
  task automatic start_c;
    if (!scl_o) begin
      tick(2);
      sda_low_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
    end
    tick(4);
    sda_low_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask : start_c

  // stop, then some bus free time so the device is seen idle
  task automatic stop_c;
    tick(2);
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_low_o = 1'b0;
    tick(8);
  endtask : stop_c

  // send a byte msb first; nak is the line level in the acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, nak);
  endtask : wr_byte

  // read a byte; acknowledge asks for more, release ends the read
  task automatic rd_byte(input logic more, output logic [7:0] d, output logic slot);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, slot);
  endtask : rd_byte
endmodule : esr_master_model

// ---- testbench.sv ----
// self-checking bench for the eeprom read sequencer with a bus master model
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] dev_code = 4'h6;  // device type code, arbitrary value
  localparam int         max_cyc  = 10000; // hang ceiling in system cycles
  logic       clk_i   = 1'b0;   // system clock
  logic       rst_i   = 1'b1;   // synchronous reset
  logic       scl;              // bus clock from master
  logic       m_low;            // master pulls data low
  logic       sda_o;            // device data value
  logic       sda_oe;           // device pulls data low
  logic       sda_line;         // resolved line with pull-up
  logic       cs_hi   = 1'b1;   // strap on the high chip select
  logic       cs_lo   = 1'b0;   // strap on the low chip select
  logic       wr_en   = 1'b0;   // array preload strobe
  logic [8:0] wr_addr = 9'h000; // preload address
  logic [7:0] wr_data = 8'h00;  // preload data
  int         fail_count = 0;   // mismatches
  int         checked    = 0;   // comparisons
  int         cyc        = 0;   // cycles run

  // open drain: low if anyone pulls, else the pull-up wins
  assign sda_line = ~(m_low | (sda_oe & ~sda_o));

  always #2 clk_i = ~clk_i;

  esr_top #(.DEV_TYPE(dev_code)) DUT (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .scl_i                  (scl),
    .sda_i                  (sda_line),
    .sda_o                  (sda_o),
    .sda_oe_o               (sda_oe),
    .chip_select_low_pin_i  (cs_lo),
    .chip_select_high_pin_i (cs_hi),
    .mem_wr_en_i            (wr_en),
    .mem_wr_addr_i          (wr_addr),
    .mem_wr_data_i          (wr_data)
  );

  esr_master_model m (
    .clk_i      (clk_i),
    .sda_line_i (sda_line),
    .scl_o      (scl),
    .sda_low_o  (m_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // a hang counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == max_cyc) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // preload pattern; the top address bit flips data bit 7
  function automatic logic [7:0] mem_of(input logic [8:0] a);
    return a[7:0] ^ {a[8], 7'h2B};
  endfunction : mem_of

  function automatic logic [7:0] slv(input logic [1:0] cs, input logic b8, input logic rw);
    return {dev_code, cs, b8, rw};
  endfunction : slv

  ////////////////////////////////////////////////////////////////////////////
  // dummy write: slave byte then address byte, no data
  task automatic dummy_write(input logic [8:0] a);
    logic nak;
    m.start_c();
    m.wr_byte(slv({cs_hi, cs_lo}, a[8], 1'b0), nak);
    check({8'h00, nak}, 9'h000);
    m.wr_byte(a[7:0], nak);
    check({8'h00, nak}, 9'h000);
  endtask : dummy_write

  // read n bytes expected from address a, acknowledging all but the last
  task automatic do_read(input logic [8:0] a, input int n);
    logic       nak;
    logic       slot;
    logic [7:0] d;
    m.start_c();
    m.wr_byte(slv({cs_hi, cs_lo}, 1'b0, 1'b1), nak);
    check({8'h00, nak}, 9'h000);
    for (int k = 0; k < n; k++) begin
      m.rd_byte(k < n - 1, d, slot);
      check({1'b0, d}, {1'b0, mem_of(a + 9'(k))});
    end
    check({8'h00, slot}, 9'h001);
    m.stop_c();
    check({8'h00, sda_oe}, 9'h000);
  endtask : do_read

  // random read at the top of the array rolls over to zero
  task automatic t_wrap;
    dummy_write(9'h1FE);
    do_read(9'h1FE, 4);
    $display("test wrap done");
  endtask : t_wrap

  // current reads carry on one past the last byte sent
  task automatic t_current;
    do_read(9'h002, 1);
    do_read(9'h003, 3);
    $display("test current done");
  endtask : t_current

  // slow master, read across the top address bit
  task automatic t_slow;
    m.lo_wait = 12;
    dummy_write(9'h0FF);
    do_read(9'h0FF, 2);
    m.lo_wait = 4;
    $display("test slow done");
  endtask : t_slow

  // each chip select pattern and a wrong type code; only the strap answers
  task automatic t_select;
    logic nak;
    for (int i = 0; i < 5; i++) begin
      m.start_c();
      m.wr_byte(i < 4 ? slv(2'(i), 1'b0, 1'b0) : 8'h98, nak);
      check({8'h00, nak}, {8'h00, i != 2});
      m.wr_byte(8'h40, nak);
      check({8'h00, nak}, {8'h00, i != 2});
      m.stop_c();
    end
    do_read(9'h040, 1);
    $display("test select done");
  endtask : t_select

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    for (int a = 0; a < 512; a++) begin
      wr_en   = 1'b1;
      wr_addr = 9'(a);
      wr_data = mem_of(9'(a));
      @(negedge clk_i);
    end
    wr_en = 1'b0;
    repeat (4) @(negedge clk_i);
    t_wrap();
    t_current();
    t_slow();
    t_select();
    end_sim();
  end
endmodule : testbench
